// ===== include/ptm_regs.vh
`ifndef PTM_REGS_VH
`define PTM_REGS_VH
// Command codes
`define PTM_CMD_READ_VOUT 8'h8B
`define PTM_CMD_READ_IOUT 8'h8C
`define PTM_CMD_READ_DUTY 8'h94
`define PTM_CMD_READ_TEMP 8'h8D
`define PTM_CMD_OV_MARGIN 8'hD0
// Linear format exponents (five-bit two's complement)
`define PTM_EXP_DUTY 5'h1E
`define PTM_EXP_UNITY 5'h00
// Voltage code step in millivolts
`define PTM_VCODE_STEP_MV 5
// Overvoltage margin decode
`define PTM_OV_SEL_RESET 2'h0
`define PTM_OV_MV_0 10'd175
`define PTM_OV_MV_1 10'd225
`define PTM_OV_MV_2 10'd275
`define PTM_OV_MV_3 10'd325
// Section select
`define PTM_SEC_MULTI 1'b0
`define PTM_SEC_SINGLE 1'b1
`endif

// ===== verilog/ptm_linear_fmt.v
`timescale 1ns/1ps
// Packs exponent and mantissa into a linear-format word, saturating the mantissa
module ptm_linear_fmt (
   input wire [4:0] exponent,
   input wire [15:0] value,
   output wire [15:0] word
);
   wire over;
   assign over = (value > 16'h0000_03FF);
   // Unsigned inputs saturate at the largest positive mantissa
   assign word = {exponent, over ? 11'h3FF : value[10:0]};
endmodule // ptm_linear_fmt

// ===== verilog/ptm_telemetry.v
`timescale 1ns/1ps
`include "ptm_regs.vh"
// What this block does
// - A duty-cycle read reports the multi-phase duty in percent as linear format with exponent minus two.
// - The duty is measured from the switching-node sense input tied to phase one of the multi-phase section.
// - An output-voltage read returns the programmed voltage code as a count of 5 mV steps for either section.
// - An output-current read returns amperes from the current monitor, linear format with exponent zero.
// - The reported current equals the serial-bus output current register value at that moment.
// - A temperature read returns the multi-phase stage temperature in Celsius, linear with exponent zero.
// - The overvoltage margin decodes 00h..03h as +175, +225, +275, +325 mV, 00h after reset.
// - Multi-phase and single-phase sections each hold their own margin setting.
// - Command 94h is a word read of duty cycle, multi-phase only.
// - Command 8Bh is a per-section word read of the voltage code.
// - Command 8Ch is a per-section word read of output current in amperes.
module ptm_telemetry #(
   parameter PERIOD_W = 16
)(
   input wire clk,
   input wire rst,
   input wire cmd_valid,
   input wire [7:0] cmd_code,
   input wire cmd_section,
   input wire cmd_is_write,
   input wire [7:0] cmd_wdata,
   input wire phase_node_sense,
   input wire [7:0] voltage_code_multi,
   input wire [7:0] voltage_code_single,
   input wire [7:0] iout_amps_multi,
   input wire [7:0] iout_amps_single,
   input wire [7:0] thermistor_sense_input,
   output reg rsp_valid,
   output reg rsp_ack,
   output reg [7:0] rsp_byte,
   output reg rsp_last,
   output reg [1:0] ov_sel_multi,
   output reg [1:0] ov_sel_single,
   output reg [9:0] ov_margin_mv_multi,
   output reg [9:0] ov_margin_mv_single
);
   localparam ST_IDLE = 2'd0;
   localparam ST_HIGH = 2'd2;

   function [9:0] ov_decode;
      input [1:0] sel;
      begin
         case (sel)
            2'd0: ov_decode = `PTM_OV_MV_0;
            2'd1: ov_decode = `PTM_OV_MV_1;
            2'd2: ov_decode = `PTM_OV_MV_2;
            default: ov_decode = `PTM_OV_MV_3;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Duty measurement on phase-one switching node
   reg [PERIOD_W-1:0] per_cnt_q;
   reg [PERIOD_W-1:0] hi_cnt_q;
   reg [PERIOD_W-1:0] per_last_q;
   reg [PERIOD_W-1:0] hi_last_q;
   reg node_prev_q;
   wire rise;
   assign rise = phase_node_sense & ~node_prev_q;

   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         per_cnt_q <= {PERIOD_W{1'b0}};
         hi_cnt_q <= {PERIOD_W{1'b0}};
         per_last_q <= {PERIOD_W{1'b0}};
         hi_last_q <= {PERIOD_W{1'b0}};
         node_prev_q <= 1'b0;
      end
      else
      begin
         node_prev_q <= phase_node_sense;
         if (rise)
         begin
            per_last_q <= per_cnt_q;
            hi_last_q <= hi_cnt_q;
            per_cnt_q <= {{(PERIOD_W-1){1'b0}}, 1'b1};
            hi_cnt_q <= {{(PERIOD_W-1){1'b0}}, 1'b1};
         end
         else
         begin
            // Saturate so a stalled node cannot wrap into a bogus duty
            if (~&per_cnt_q)
               per_cnt_q <= per_cnt_q + 1'b1;
            if (phase_node_sense && ~&hi_cnt_q)
               hi_cnt_q <= hi_cnt_q + 1'b1;
         end
      end
   end

   // Percent in quarter steps: 400 * high / period, exponent -2
   wire [PERIOD_W+8:0] duty_num;
   wire [PERIOD_W+8:0] duty_q4;
   assign duty_num = hi_last_q * 9'd400;
   assign duty_q4 = (per_last_q == {PERIOD_W{1'b0}}) ? {(PERIOD_W+9){1'b0}} :
                    duty_num / per_last_q;

   ////////////////////////////////////////////////////////////////////////
   // Word formatting
   wire [15:0] duty_word;
   wire [15:0] iout_word;
   wire [15:0] temp_word;
   wire [7:0] iout_sel;
   assign iout_sel = cmd_section ? iout_amps_single : iout_amps_multi;

   ptm_linear_fmt u_fmt_duty (
      .exponent(`PTM_EXP_DUTY),
      .value(duty_q4[15:0]),
      .word(duty_word)
   );
   ptm_linear_fmt u_fmt_iout (
      .exponent(`PTM_EXP_UNITY),
      .value({8'h00, iout_sel}),
      .word(iout_word)
   );
   ptm_linear_fmt u_fmt_temp (
      .exponent(`PTM_EXP_UNITY),
      .value({8'h00, thermistor_sense_input}),
      .word(temp_word)
   );

   ////////////////////////////////////////////////////////////////////////
   // Command decode
   reg [15:0] word_d;
   reg hit_d;
   always @*
   begin
      word_d = 16'h0000;
      hit_d = 1'b0;
      case (cmd_code)
         `PTM_CMD_READ_VOUT:
         begin
            hit_d = 1'b1;
            word_d = {8'h00, cmd_section ? voltage_code_single : voltage_code_multi};
         end
         `PTM_CMD_READ_IOUT:
         begin
            hit_d = 1'b1;
            word_d = iout_word;
         end
         `PTM_CMD_READ_DUTY:
         begin
            // Single-phase has no duty monitor
            hit_d = (cmd_section == `PTM_SEC_MULTI);
            word_d = duty_word;
         end
         `PTM_CMD_READ_TEMP:
         begin
            hit_d = 1'b1;
            word_d = temp_word;
         end
         default:
         begin
            word_d = 16'h0000;
            hit_d = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Answer sequencer and margin settings
   reg [1:0] state_q;
   reg [7:0] high_q;
   wire ov_write;
   assign ov_write = cmd_valid && cmd_is_write && (cmd_code == `PTM_CMD_OV_MARGIN) && (state_q == ST_IDLE);
   wire ov_data_ok;
   wire ov_take;
   assign ov_data_ok = (cmd_wdata[7:2] == 6'h00);
   // Out-of-range data is refused whole, so the old margin stays in force
   assign ov_take = ov_write && ov_data_ok;

   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state_q <= ST_IDLE;
         high_q <= 8'h00;
         rsp_valid <= 1'b0;
         rsp_ack <= 1'b0;
         rsp_byte <= 8'h00;
         rsp_last <= 1'b0;
         ov_sel_multi <= `PTM_OV_SEL_RESET;
         ov_sel_single <= `PTM_OV_SEL_RESET;
         ov_margin_mv_multi <= `PTM_OV_MV_0;
         ov_margin_mv_single <= `PTM_OV_MV_0;
      end
      else
      begin
         ov_margin_mv_multi <= ov_decode(ov_sel_multi);
         ov_margin_mv_single <= ov_decode(ov_sel_single);
         if (ov_take && cmd_section == `PTM_SEC_MULTI)
            ov_sel_multi <= cmd_wdata[1:0];
         if (ov_take && cmd_section == `PTM_SEC_SINGLE)
            ov_sel_single <= cmd_wdata[1:0];
         rsp_valid <= 1'b0;
         rsp_ack <= 1'b0;
         rsp_last <= 1'b0;
         case (state_q)
            ST_IDLE:
            begin
               if (cmd_valid && !cmd_is_write)
               begin
                  rsp_ack <= hit_d;
                  if (hit_d)
                  begin
                     high_q <= word_d[15:8];
                     rsp_byte <= word_d[7:0];
                     rsp_valid <= 1'b1;
                     state_q <= ST_HIGH;
                  end
               end
               else if (ov_write)
                  rsp_ack <= ov_data_ok;
            end
            ST_HIGH:
            begin
               rsp_byte <= high_q;
               rsp_valid <= 1'b1;
               rsp_last <= 1'b1;
               state_q <= ST_IDLE;
            end
            default:
               state_q <= ST_IDLE;
         endcase
      end
   end
endmodule // ptm_telemetry

// ===== testbench/ptm_props.sv
`timescale 1ns/1ps
module ptm_props (
   input wire clk,
   input wire rst,
   input wire cmd_valid,
   input wire [7:0] cmd_code,
   input wire cmd_section,
   input wire cmd_is_write,
   input wire [7:0] cmd_wdata,
   input wire [7:0] voltage_code_multi,
   input wire [7:0] iout_amps_single,
   input wire rsp_valid,
   input wire rsp_ack,
   input wire [7:0] rsp_byte,
   input wire rsp_last,
   input wire [1:0] ov_sel_multi,
   input wire [1:0] ov_sel_single,
   input wire [9:0] ov_margin_mv_multi,
   input wire [9:0] ov_margin_mv_single
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   wire rd = cmd_valid & ~cmd_is_write;
   wire wr = cmd_valid & cmd_is_write & (cmd_code == 8'hd0);
   chk_iout_pair: assert property (rd && cmd_code == 8'h8c |=> (rsp_ack && rsp_valid) ##1 (rsp_valid && rsp_last))
      else $error("current read framing wrong");
   chk_vout_word: assert property (rd && cmd_code == 8'h8b && !cmd_section
      |=> (rsp_byte == $past(voltage_code_multi)) ##1 (rsp_byte == 8'h00)) else $error("voltage code word wrong");
   chk_iout_match: assert property (rd && cmd_code == 8'h8c && cmd_section |=> rsp_byte == $past(iout_amps_single))
      else $error("current byte differs from input");
   chk_duty_refuse: assert property (cmd_valid && cmd_code == 8'h94 && cmd_section |=> !rsp_valid && !rsp_ack)
      else $error("duty read on single section answered");
   chk_duty_exp: assert property (rd && cmd_code == 8'h94 && !cmd_section |=> ##1 rsp_last && rsp_byte[7:3] == 5'h1e)
      else $error("duty exponent wrong");
   chk_ov_write: assert property (wr && cmd_wdata < 8'h04 && !cmd_section
      |=> rsp_ack && ov_sel_multi == $past(cmd_wdata[1:0]) && $stable(ov_sel_single)) else $error("margin write wrong");
   chk_ov_bad: assert property (wr && cmd_wdata > 8'h03
      |=> !rsp_ack && $stable(ov_sel_multi) && $stable(ov_sel_single)) else $error("bad margin data accepted");
   chk_ov_decode: assert property (ov_margin_mv_multi == 10'h0af + 10'h032 * $past(ov_sel_multi))
      else $error("multi margin decode wrong");
   chk_ov_single: assert property (ov_margin_mv_single == 10'h0af + 10'h032 * $past(ov_sel_single))
      else $error("single margin decode wrong");
endmodule // ptm_props
bind ptm_telemetry ptm_props u_props (
   .clk(clk),
   .rst(rst),
   .cmd_valid(cmd_valid),
   .cmd_code(cmd_code),
   .cmd_section(cmd_section),
   .cmd_is_write(cmd_is_write),
   .cmd_wdata(cmd_wdata),
   .voltage_code_multi(voltage_code_multi),
   .iout_amps_single(iout_amps_single),
   .rsp_valid(rsp_valid),
   .rsp_ack(rsp_ack),
   .rsp_byte(rsp_byte),
   .rsp_last(rsp_last),
   .ov_sel_multi(ov_sel_multi),
   .ov_sel_single(ov_sel_single),
   .ov_margin_mv_multi(ov_margin_mv_multi),
   .ov_margin_mv_single(ov_margin_mv_single)
);

// ===== testbench/ptm_host.sv
`timescale 1ns/1ps
module ptm_host (
   input wire clk,
   output logic cmd_valid = 1'b0,
   output logic [7:0] cmd_code = 8'h00,
   output logic cmd_section = 1'b0,
   output logic cmd_is_write = 1'b0,
   output logic [7:0] cmd_wdata = 8'h00,
   input wire rsp_valid,
   input wire rsp_ack,
   input wire rsp_last,
   input wire [7:0] rsp_byte
);
   // Three cycles per call, so reads never come closer than allowed
   task xfer(input logic [7:0] c, input logic s, input logic w, input logic [7:0] d,
      output logic [15:0] wd, output logic [2:0] fl);
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd_code = c;
      cmd_section = s;
      cmd_is_write = w;
      cmd_wdata = d;
      @(negedge clk);
      cmd_valid = 1'b0;
      // Scrambled so a design reading stale fields shows up
      cmd_code = ~c;
      cmd_wdata = ~d;
      fl = {rsp_ack, rsp_valid, 1'b0};
      wd[7:0] = rsp_byte;
      @(negedge clk);
      wd[15:8] = rsp_byte;
      fl[0] = rsp_valid & rsp_last;
   endtask
endmodule // ptm_host

// ===== testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic phase_node_sense = 1'b0;
   logic pwm_en = 1'b0;
   logic [5:0] pwm_cnt = 6'h00;
   logic [7:0] voltage_code_multi = 8'h00, voltage_code_single = 8'h00, thermistor_sense_input = 8'h00;
   logic [7:0] iout_amps_multi = 8'h00, iout_amps_single = 8'h00;
   logic [15:0] wd;
   logic [2:0] fl;
   int error_cnt = 0;
   int n_checks = 0;
   wire cmd_valid, cmd_section, cmd_is_write, rsp_valid, rsp_ack, rsp_last;
   wire [7:0] cmd_code, cmd_wdata, rsp_byte;
   wire [1:0] ov_sel_multi, ov_sel_single;
   wire [9:0] ov_margin_mv_multi, ov_margin_mv_single;
   initial
   begin
      forever #5 clk = ~clk;
   end
   // Phase node high 10 of every 40 cycles
   always @(negedge clk)
   begin
      pwm_cnt <= (pwm_cnt == 6'h27) ? 6'h00 : pwm_cnt + 6'h01;
      phase_node_sense <= pwm_en && pwm_cnt < 6'h0a;
   end
   ptm_host host (
      .clk(clk),
      .cmd_valid(cmd_valid),
      .cmd_code(cmd_code),
      .cmd_section(cmd_section),
      .cmd_is_write(cmd_is_write),
      .cmd_wdata(cmd_wdata),
      .rsp_valid(rsp_valid),
      .rsp_ack(rsp_ack),
      .rsp_last(rsp_last),
      .rsp_byte(rsp_byte)
   );
   ptm_telemetry dut (
      .clk(clk),
      .rst(rst),
      .cmd_valid(cmd_valid),
      .cmd_code(cmd_code),
      .cmd_section(cmd_section),
      .cmd_is_write(cmd_is_write),
      .cmd_wdata(cmd_wdata),
      .phase_node_sense(phase_node_sense),
      .voltage_code_multi(voltage_code_multi),
      .voltage_code_single(voltage_code_single),
      .iout_amps_multi(iout_amps_multi),
      .iout_amps_single(iout_amps_single),
      .thermistor_sense_input(thermistor_sense_input),
      .rsp_valid(rsp_valid),
      .rsp_ack(rsp_ack),
      .rsp_byte(rsp_byte),
      .rsp_last(rsp_last),
      .ov_sel_multi(ov_sel_multi),
      .ov_sel_single(ov_sel_single),
      .ov_margin_mv_multi(ov_margin_mv_multi),
      .ov_margin_mv_single(ov_margin_mv_single)
   );
   ////////////////////////////////////////////////////////////////////////////
   task chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task summarize;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task t_read(input logic [7:0] c, input logic s, input logic [15:0] e);
      host.xfer(c, s, 1'b0, 8'h00, wd, fl);
      chk(wd, e);
      chk(fl, 3'h7);
   endtask
   task t_reset;
      chk(ov_margin_mv_multi, 10'h0af);
      chk(ov_margin_mv_single, 10'h0af);
      chk({ov_sel_multi, ov_sel_single}, 4'h0);
   endtask
   // Reset again after the margins were moved, to see them fall back
   task t_rerst;
      rst = 1'b1;
      repeat (3) @(negedge clk);
      rst = 1'b0;
      t_reset;
      t_read(8'h8b, 1'b0, 16'h00c8);
   endtask
   task t_monitors;
      voltage_code_multi = 8'hc8;
      voltage_code_single = 8'h37;
      iout_amps_multi = 8'h12;
      iout_amps_single = 8'hff;
      thermistor_sense_input = 8'h55;
      t_read(8'h8b, 1'b0, 16'h00c8);
      t_read(8'h8b, 1'b1, 16'h0037);
      t_read(8'h8c, 1'b0, 16'h0012);
      t_read(8'h8c, 1'b1, 16'h00ff);
      t_read(8'h8d, 1'b1, 16'h0055);
   endtask
   task t_duty;
      t_read(8'h94, 1'b0, 16'hf000);
      pwm_en = 1'b1;
      // Enough for two whole periods of the phase node
      repeat (120) @(negedge clk);
      t_read(8'h94, 1'b0, 16'hf064);
      host.xfer(8'h94, 1'b1, 1'b0, 8'h00, wd, fl);
      chk(fl, 3'h0);
   endtask
   task t_margin;
      for (int d = 0; d < 4; d++)
      begin
         host.xfer(8'hd0, 1'b0, 1'b1, d[7:0], wd, fl);
         chk(fl, 3'h4);
         host.xfer(8'hd0, 1'b1, 1'b1, 8'h03 - d[7:0], wd, fl);
         chk(ov_sel_single, 2'h3 - d[1:0]);
         chk(ov_margin_mv_multi, 10'h0af + 10'h032 * d[9:0]);
         chk(ov_margin_mv_single, 10'h0af + 10'h032 * (10'h003 - d[9:0]));
      end
      host.xfer(8'hd0, 1'b0, 1'b1, 8'h04, wd, fl);
      chk({fl, ov_sel_multi}, 5'h03);
      host.xfer(8'hd0, 1'b1, 1'b1, 8'hff, wd, fl);
      chk({fl, ov_sel_single}, 5'h00);
   endtask
   initial
   begin
      repeat (3) @(negedge clk);
      rst = 1'b0;
      t_reset;
      t_monitors;
      t_duty;
      t_margin;
      t_rerst;
      summarize;
   end
endmodule // testbench
